// File: common/rchf_pkg.sv
// Shared constants and carrier types of the return-link cell framer.
// Assumes one clock domain; every user of these types imports rchf_pkg::*.
package rchf_pkg;

  // Cell geometry, native cell mode and transport-stream mode
  localparam int unsigned CELL_LEN     = 53;
  localparam int unsigned ATM_HDR_LEN  = 5;
  localparam int unsigned ATM_PAY_LEN  = 48;
  localparam int unsigned TS_HDR_LEN   = 4;
  localparam int unsigned TS_PAY_LEN   = 184;
  localparam int unsigned BUF_DEPTH    = 2;

  // Header check coding
  localparam logic [7:0]  HEC_POLY     = 8'h07;
  localparam logic [7:0]  HEC_COSET    = 8'h55;
  localparam logic [3:0]  GFC_RSVD     = 4'h0;
  localparam logic        CONG_BIT     = 1'b0;
  localparam logic        CLP_BIT      = 1'b0;

  // Default connection signalling circuit
  localparam logic [7:0]  SIG_VPI      = 8'h00;
  localparam logic [15:0] SIG_VCI      = 16'h0005;

  // Transport-stream header fields
  localparam logic [7:0]  TS_SYNC      = 8'h47;
  localparam logic [1:0]  TS_SCRAMBLE  = 2'h0;
  localparam logic [1:0]  TS_AFC_PAY   = 2'h1;

  // Reserved addresses
  localparam logic [7:0]  GROUP_RSVD   = 8'hFF;
  localparam logic [15:0] MEMBER_CONT  = 16'hFFFF;
  localparam logic [47:0] MAC_BCAST    = 48'hFFFF_FFFF_FFFF;

  // Framer states, Gray along idle -> header -> payload
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_PAY  = 2'b11
  } rchf_state_t;

  // Byte on the outgoing stream
  typedef struct packed {
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } rchf_byte_t;

  // Per-cell request
  typedef struct packed {
    logic ctrl;        // control_management_burst when set
    logic frame_end;   // frame_end_indication
    logic frame_start; // first packet of a datagram (transport-stream mode)
  } rchf_cell_t;

  // Logon assignment
  typedef struct packed {
    logic [7:0]  terminal_group_address;
    logic [15:0] member_address;
    logic        vc_valid;
    logic [7:0]  vpi;
    logic [15:0] vci;
    logic [12:0] pid_trf;
    logic [12:0] pid_ctl;
  } rchf_assign_t;

endpackage : rchf_pkg

// File: hdl/rchf_framer.sv
// Return-link cell framer with logon addressing and burst-plan slot check.
// Assumes synchronous inputs on core_clk and a single synchronous reset.
//
// Notes on behaviour
// [R1] Native cells are 53 bytes: 5 header bytes then 48 payload bytes.
// [R2] Generic flow control is reserved unless the security mechanism is active.
// [R3] VPI and VCI come from the logon assignment or higher-layer signalling.
// [R4] The network never gives one VPI/VCI pair to two terminals at once.
// [R5] Octet 4 bit 2 carries the frame-end indication of the last cell.
// [R6] Octet 4 bit 3, congestion, is always zero.
// [R7] Octet 4 bit 4 is 0 for traffic, 1 for control/management bursts.
// [R8] Cell loss priority is always zero.
// [R9] Fifth header byte is the header error check over four bytes.
// [R10] Check is CRC-8 with x^8+x^2+x+1, then XOR 0x55.
// [R11] Routed datagrams go in the payload with no protocol identification header.
// [R12] Transport-stream mode uses the traffic and control packet ids from logon.
// [R13] Assigned VPI/VCI replaces the default 0/5 signalling circuit.
// [R14] No return-link transmission unless control information is received correctly; bytes of a fully written cell still drain.
// [R15] Group address is 8 bits; 0xFF is reserved and never assigned.
// [R16] Member address is 16 bits; 0xFFFF means contention access.
// [R17] Logon addresses are kept and used to match messages until logoff.
// [R18] Unicast forward user data uses the terminal's own MAC address.
// [R19] All-ones broadcast MAC address is accepted as the terminal's own.
// [R20] A slot grant covers start slot plus repetition-factor consecutive slots; the code grants bp_reps slots in all, start slot included.
// [R21] Without security, generic flow control is driven to zeros.
`timescale 1ns/1ps
module rchf_framer #(
  parameter int unsigned SLOT_W = 16,
  parameter int unsigned REP_W  = 8
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // Mode and status
  input  wire logic                  ctrl_rx_ok,
  input  wire logic                  mpeg_mode,
  input  wire logic                  security_on,
  input  wire logic [3:0]            security_gfc,
  output      logic                  logged_on_ff,
  output      logic                  tx_enable_ff,
  // Logon assignment and logoff
  input  wire logic                  assign_stb,
  input  wire rchf_pkg::rchf_assign_t assign_in,
  input  wire logic                  logoff_stb,
  output      logic                  assign_err_ff,
  output      logic                  contention_ff,
  // Cell requests
  input  wire logic                  cell_req,
  input  wire rchf_pkg::rchf_cell_t  cell_in,
  output      logic                  cell_ack_ff,
  output      logic                  cell_abort_ff,
  // Payload bytes in
  input  wire logic                  in_valid,
  input  wire logic [7:0]            in_data,
  output      logic                  in_ready_ff,
  // Cell bytes out
  output      logic                  out_valid_ff,
  output      rchf_pkg::rchf_byte_t  out_byte_ff,
  input  wire logic                  out_ready,
  // Forward-link address check
  input  wire logic                  fwd_check,
  input  wire logic [47:0]           fwd_mac,
  input  wire logic [47:0]           own_mac,
  input  wire logic [7:0]            fwd_group,
  input  wire logic [15:0]           fwd_member,
  output      logic                  mac_hit_ff,
  output      logic                  logical_hit_ff,
  // Burst plan
  input  wire logic                  bp_load,
  input  wire logic [SLOT_W-1:0]     bp_start,
  input  wire logic [REP_W-1:0]      bp_reps,
  input  wire logic                  slot_tick,
  input  wire logic [SLOT_W-1:0]     cur_slot,
  output      logic                  slot_grant_ff
);
  import rchf_pkg::*;

  // CRC-8 over 32 header bits, most significant first, then coset
  function automatic logic [7:0] hec_calc(input logic [31:0] hdr);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (crc[7] ^ hdr[i])
        crc = {crc[6:0], 1'b0} ^ HEC_POLY;
      else
        crc = {crc[6:0], 1'b0};
    end
    return crc ^ HEC_COSET;
  endfunction : hec_calc

  // Exact match or all-ones broadcast on a MAC address
  function automatic logic mac_match(input logic [47:0] a, input logic [47:0] mine);
    return (a == mine) || (a == MAC_BCAST);
  endfunction : mac_match

  rchf_assign_t        asg_ff;
  rchf_state_t         state_ff;
  rchf_state_t         nxt_state;
  logic [7:0]          idx_ff;
  logic [7:0]          nxt_idx;
  logic [7:0]          hdr_ff [ATM_HDR_LEN];
  logic [7:0]          hdr_last_ff;
  logic [7:0]          pay_last_ff;
  logic [3:0]          cc_ff [2];
  logic                ts_ctl_ff;
  rchf_byte_t          skid_ff;
  logic                skid_v_ff;
  logic                wr_en;
  rchf_byte_t          wr_byte;
  logic                rd_en;
  logic [1:0]          cnt;
  logic [1:0]          nxt_cnt;
  logic                abort;
  logic [SLOT_W-1:0]   bp_start_ff;
  logic [REP_W-1:0]    bp_reps_ff;
  logic [SLOT_W-1:0]   slot_off;
  logic [7:0]          vpi_sel;
  logic [15:0]         vci_sel;
  logic [3:0]          gfc_sel;
  logic [12:0]         pid_sel;
  logic [31:0]         hdr_word;

  // Logon assignment held until logoff
  // [R15] reserved group refused
  // [R16] member width and contention value
  // [R17] hold until logoff
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      logged_on_ff  <= 1'b0;
      asg_ff        <= '0;
      assign_err_ff <= 1'b0;
      contention_ff <= 1'b0;
    end
    else
    begin
      assign_err_ff <= 1'b0;
      if (logoff_stb)
      begin
        logged_on_ff  <= 1'b0;
        asg_ff        <= '0;
        contention_ff <= 1'b0;
      end
      else if (assign_stb)
      begin
        if (assign_in.terminal_group_address == GROUP_RSVD)
          assign_err_ff <= 1'b1;
        else
        begin
          logged_on_ff  <= 1'b1;
          asg_ff        <= assign_in;
          contention_ff <= (assign_in.member_address == MEMBER_CONT);
        end
      end
    end
  end

  // [R14] transmit only with good control reception
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      tx_enable_ff <= 1'b0;
    else
      tx_enable_ff <= ctrl_rx_ok && logged_on_ff && !logoff_stb;
  end

  // Header field selection for a new cell
  always_comb
  begin
    // [R13] defaults until a circuit is assigned
    // [R3] assigned circuit
    if (asg_ff.vc_valid)
    begin
      vpi_sel = asg_ff.vpi;
      vci_sel = asg_ff.vci;
    end
    else
    begin
      vpi_sel = SIG_VPI;
      vci_sel = SIG_VCI;
    end
    // [R2] security meaning of flow control
    // [R21] zero when reserved
    gfc_sel = security_on ? security_gfc : GFC_RSVD;
    // [R12] logon packet ids
    pid_sel = cell_in.ctrl ? asg_ff.pid_ctl : asg_ff.pid_trf;
    // [R5] frame end in bit 2
    // [R6] congestion bit zero
    // [R7] control burst bit 4
    // [R8] loss priority zero
    hdr_word = {gfc_sel, vpi_sel, vci_sel, cell_in.ctrl, CONG_BIT,
                cell_in.frame_end, CLP_BIT};
  end

  assign cnt     = 2'(out_valid_ff) + 2'(skid_v_ff);
  assign rd_en   = out_valid_ff && out_ready;
  assign nxt_cnt = cnt + 2'(wr_en) - 2'(rd_en);
  assign abort   = !tx_enable_ff && (state_ff != ST_IDLE);

  // Cell sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    wr_en     = 1'b0;
    wr_byte   = '0;
    case (state_ff)
      ST_IDLE:
      begin
        if (cell_req && tx_enable_ff)
        begin
          nxt_state = ST_HDR;
          nxt_idx   = 8'h00;
        end
      end
      ST_HDR:
      begin
        if (cnt < 2'(BUF_DEPTH))
        begin
          wr_en        = 1'b1;
          wr_byte.data = hdr_ff[3'(idx_ff)];
          wr_byte.sof  = (idx_ff == 8'h00);
          if (idx_ff == hdr_last_ff)
          begin
            nxt_state = ST_PAY;
            nxt_idx   = 8'h00;
          end
          else
            nxt_idx = idx_ff + 8'h01;
        end
      end
      ST_PAY:
      begin
        // [R11] payload passes through untouched
        if (in_valid && in_ready_ff)
        begin
          wr_en        = 1'b1;
          wr_byte.data = in_data;
          wr_byte.eof  = (idx_ff == pay_last_ff);
          if (idx_ff == pay_last_ff)
            nxt_state = ST_IDLE;
          else
            nxt_idx = idx_ff + 8'h01;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn || abort)
    begin
      state_ff    <= ST_IDLE;
      idx_ff      <= 8'h00;
      in_ready_ff <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      idx_ff      <= nxt_idx;
      in_ready_ff <= (nxt_state == ST_PAY) && (nxt_cnt < 2'(BUF_DEPTH));
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cell_ack_ff   <= 1'b0;
      cell_abort_ff <= 1'b0;
    end
    else
    begin
      cell_ack_ff   <= (state_ff == ST_IDLE) && cell_req && tx_enable_ff;
      cell_abort_ff <= abort;
    end
  end

  // Header latched when a cell is taken
  // [R1] 5 + 48 byte cell
  // [R9] check byte fifth
  // [R10] CRC-8 with coset
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < ATM_HDR_LEN; i++)
        hdr_ff[i] <= 8'h00;
      hdr_last_ff <= 8'(ATM_HDR_LEN - 1);
      pay_last_ff <= 8'(ATM_PAY_LEN - 1);
      ts_ctl_ff   <= 1'b0;
    end
    else if ((state_ff == ST_IDLE) && cell_req && tx_enable_ff)
    begin
      ts_ctl_ff <= cell_in.ctrl;
      if (mpeg_mode)
      begin
        hdr_ff[0]   <= TS_SYNC;
        hdr_ff[1]   <= {1'b0, cell_in.frame_start, 1'b0, pid_sel[12:8]};
        hdr_ff[2]   <= pid_sel[7:0];
        hdr_ff[3]   <= {TS_SCRAMBLE, TS_AFC_PAY, cc_ff[cell_in.ctrl]};
        hdr_ff[4]   <= 8'h00;
        hdr_last_ff <= 8'(TS_HDR_LEN - 1);
        pay_last_ff <= 8'(TS_PAY_LEN - 1);
      end
      else
      begin
        hdr_ff[0]   <= hdr_word[31:24];
        hdr_ff[1]   <= hdr_word[23:16];
        hdr_ff[2]   <= hdr_word[15:8];
        hdr_ff[3]   <= hdr_word[7:0];
        hdr_ff[4]   <= hec_calc(hdr_word);
        hdr_last_ff <= 8'(ATM_HDR_LEN - 1);
        pay_last_ff <= 8'(ATM_PAY_LEN - 1);
      end
    end
  end

  // Continuity counters, one per packet id, advance on completed packets
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_cc
      always_ff @(posedge core_clk)
      begin
        if (!resetn)
          cc_ff[g] <= 4'h0;
        else if (wr_en && wr_byte.eof && mpeg_mode && (ts_ctl_ff == 1'(g)))
          cc_ff[g] <= cc_ff[g] + 4'h1;
      end
    end
  endgenerate

  // Two-entry buffer: output register plus skid entry; flushed on abort
  // [R14] flushed once tx_enable_ff drops mid-cell; bytes of a fully written cell still drain
  always_ff @(posedge core_clk)
  begin
    if (!resetn || abort)
    begin
      out_valid_ff <= 1'b0;
      out_byte_ff  <= '0;
      skid_v_ff    <= 1'b0;
      skid_ff      <= '0;
    end
    else if (rd_en || !out_valid_ff)
    begin
      if (skid_v_ff)
      begin
        out_valid_ff <= 1'b1;
        out_byte_ff  <= skid_ff;
        skid_v_ff    <= wr_en;
        skid_ff      <= wr_byte;
      end
      else
      begin
        out_valid_ff <= wr_en;
        out_byte_ff  <= wr_en ? wr_byte : out_byte_ff;
        skid_v_ff    <= 1'b0;
      end
    end
    else if (wr_en)
    begin
      skid_v_ff <= 1'b1;
      skid_ff   <= wr_byte;
    end
  end

  // Forward-link address recognition
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      mac_hit_ff     <= 1'b0;
      logical_hit_ff <= 1'b0;
    end
    else
    begin
      // [R18] own unicast address
      // [R19] broadcast accepted
      mac_hit_ff     <= fwd_check && mac_match(fwd_mac, own_mac);
      // [R17] logical match while logged on
      logical_hit_ff <= fwd_check && logged_on_ff
                        && (fwd_group == asg_ff.terminal_group_address)
                        && (fwd_member == asg_ff.member_address);
    end
  end

  // Burst-plan assignment and slot grant
  assign slot_off = cur_slot - bp_start_ff;

  always_ff @(posedge core_clk)
  begin
    if (!resetn || logoff_stb)
    begin
      bp_start_ff   <= '0;
      bp_reps_ff    <= '0;
      slot_grant_ff <= 1'b0;
    end
    else
    begin
      if (bp_load)
      begin
        bp_start_ff <= bp_start;
        bp_reps_ff  <= bp_reps;
      end
      // [R20] start plus repetition window
      slot_grant_ff <= slot_tick && logged_on_ff && (cur_slot >= bp_start_ff)
                       && (slot_off < SLOT_W'(bp_reps_ff));
    end
  end

endmodule : rchf_framer

// File: tb/rchf_framer_assertions.sv
// Port checker for the return-link cell framer.
// Assumes native cell mode while header bytes are judged.
`timescale 1ns/1ps
module rchf_framer_chk
  import rchf_pkg::*;
(
  // Clock, reset, status
  input wire logic          core_clk,
  input wire logic          resetn,
  input wire logic          ctrl_rx_ok,
  input wire logic          mpeg_mode,
  input wire logic          logged_on_ff,
  input wire logic          tx_enable_ff,
  // Logon
  input wire logic          assign_stb,
  input wire rchf_assign_t  assign_in,
  input wire logic          logoff_stb,
  input wire logic          assign_err_ff,
  input wire logic          contention_ff,
  // Cells and stream
  input wire logic          cell_req,
  input wire logic          cell_ack_ff,
  input wire logic          out_valid_ff,
  input wire rchf_byte_t    out_byte_ff,
  input wire logic          out_ready,
  // Address check
  input wire logic          fwd_check,
  input wire logic [47:0]   fwd_mac,
  input wire logic [47:0]   own_mac,
  input wire logic          mac_hit_ff
);
  logic [5:0] idx_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Bytes taken since the last start of cell
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      idx_ff <= 6'h0;
    else if (out_valid_ff && out_ready)
      idx_ff <= out_byte_ff.sof ? 6'h1 : idx_ff + 6'h1;
  end

  a_tx_needs_ctrl: assert property (
    tx_enable_ff |-> $past(ctrl_rx_ok) && $past(logged_on_ff))
    else $error("tx enabled without control or logon");
  a_ack_needs_tx: assert property (
    cell_ack_ff |-> $past(tx_enable_ff) && $past(cell_req))
    else $error("cell taken while disabled");
  a_group_refused: assert property (
    assign_stb && !logoff_stb && assign_in.terminal_group_address == GROUP_RSVD
    |=> assign_err_ff && $stable(logged_on_ff))
    else $error("reserved group accepted");
  a_member_cont: assert property (
    assign_stb && !logoff_stb && assign_in.terminal_group_address != GROUP_RSVD
    |=> contention_ff == ($past(assign_in.member_address) == MEMBER_CONT))
    else $error("contention flag wrong");
  a_logoff_clears: assert property (
    logoff_stb |=> !logged_on_ff && !tx_enable_ff)
    else $error("logoff did not clear");
  a_mac_hit: assert property (
    fwd_check && (fwd_mac == own_mac || fwd_mac == MAC_BCAST) |=> mac_hit_ff)
    else $error("mac hit missing");
  a_mac_cause: assert property (
    mac_hit_ff |-> $past(fwd_check))
    else $error("mac hit without check");
  a_octet4_bits: assert property (
    out_valid_ff && !out_byte_ff.sof && idx_ff == 6'h3 && !mpeg_mode
    |-> out_byte_ff.data[2] == 1'b0 && out_byte_ff.data[0] == 1'b0)
    else $error("congestion or loss bit set");
  a_eof_place: assert property (
    out_valid_ff && out_byte_ff.eof && !mpeg_mode |-> idx_ff == 6'h34)
    else $error("cell end at wrong byte");
  // Abort flushes the buffer on purpose, so only a live link must hold
  a_hold_stall: assert property (
    out_valid_ff && !out_ready && tx_enable_ff |=> out_valid_ff && $stable(out_byte_ff))
    else $error("byte lost under stall");

  c_refused: cover property (assign_err_ff);
  c_cell_end: cover property (out_valid_ff && out_ready && out_byte_ff.eof);
  c_mac: cover property (mac_hit_ff);
endmodule : rchf_framer_chk

bind rchf_framer rchf_framer_chk u_chk (.core_clk, .resetn, .ctrl_rx_ok, .mpeg_mode,
  .logged_on_ff, .tx_enable_ff, .assign_stb, .assign_in, .logoff_stb, .assign_err_ff,
  .contention_ff, .cell_req, .cell_ack_ff, .out_valid_ff, .out_byte_ff, .out_ready,
  .fwd_check, .fwd_mac, .own_mac, .mac_hit_ff);

// File: tb/rchf_framer_tb.sv
// Self-checking bench of the return-link cell framer.
// Assumes the far-side sink model drives out_ready.
`timescale 1ns/1ps
module rchf_framer_tb;
  import rchf_pkg::*;
  logic core_clk, resetn, ctrl_rx_ok, mpeg_mode, security_on, slow;
  logic [3:0] security_gfc;
  logic logged_on_ff, tx_enable_ff, assign_stb, logoff_stb, assign_err_ff, contention_ff;
  rchf_assign_t assign_in;
  rchf_cell_t cell_in;
  rchf_byte_t out_byte_ff;
  logic cell_req, cell_ack_ff, cell_abort_ff, in_valid, in_ready_ff, out_valid_ff, out_ready;
  logic fwd_check, mac_hit_ff, logical_hit_ff, bp_load, slot_tick, slot_grant_ff;
  logic [7:0] in_data, fwd_group, bp_reps;
  logic [47:0] fwd_mac, own_mac;
  logic [15:0] fwd_member, bp_start, cur_slot;
  int err_count, num_checks;
  rchf_byte_t cell_q[$];

  rchf_framer u_dut (.core_clk, .resetn, .ctrl_rx_ok, .mpeg_mode, .security_on,
    .security_gfc, .logged_on_ff, .tx_enable_ff, .assign_stb, .assign_in, .logoff_stb,
    .assign_err_ff, .contention_ff, .cell_req, .cell_in, .cell_ack_ff, .cell_abort_ff,
    .in_valid, .in_data, .in_ready_ff, .out_valid_ff, .out_byte_ff, .out_ready,
    .fwd_check, .fwd_mac, .own_mac, .fwd_group, .fwd_member, .mac_hit_ff,
    .logical_hit_ff, .bp_load, .bp_start, .bp_reps, .slot_tick, .cur_slot, .slot_grant_ff);
  rchf_sink u_sink (.core_clk, .resetn, .slow, .out_ready);

  initial
  begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Header check: CRC-8 over the first four bytes, then the coset
  function automatic logic [7:0] hec(logic [31:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c ^ 8'h55;
  endfunction : hec

  // Strobe is left high so that back-to-back assignments keep it steady
  task automatic logon(logic [7:0] g, logic [15:0] m, logic v);
    assign_in = '{g, m, v, 8'h12, 16'h0345, 13'h0021, 13'h0022};
    assign_stb = 1;
    tick();
  endtask : logon

  task automatic t_logon();
    logon(8'hFF, 16'h0001, 1'b1);
    check("assign_err", assign_err_ff, 1);
    check("logged_on", logged_on_ff, 0);
    logon(8'h3C, 16'hFFFF, 1'b1);
    check("contention", contention_ff, 1);
    logon(8'h3C, 16'h0101, 1'b1);
    check("contention", contention_ff, 0);
    check("logged_on", logged_on_ff, 1);
    assign_stb = 0;
    tick();
    check("tx_enable", tx_enable_ff, 1);
  endtask : t_logon

  // One cell or transport packet; vc is the expected VPI/VCI pair
  task automatic t_cell(logic ctl, logic fe, logic ts, logic [23:0] vc);
    logic [31:0] h;
    logic rp, op;
    rchf_byte_t ob;
    int k, hl, pl;
    k = 0;
    rp = 0;
    op = 0;
    ob = '0;
    hl = ts ? TS_HDR_LEN : ATM_HDR_LEN;
    pl = ts ? TS_PAY_LEN : ATM_PAY_LEN;
    cell_q.delete();
    if (ts)
      h = {TS_SYNC, 1'b0, fe, 6'h00, ctl ? 8'h22 : 8'h21, 8'h10};
    else
      h = {security_on ? security_gfc : 4'h0, vc, ctl, 1'b0, fe, 1'b0};
    cell_in = '{ctl, fe, fe};
    cell_req = 1;
    for (int n = 0; n < 20 && cell_ack_ff !== 1'b1; n++)
      tick();
    cell_req = 0;
    if (cell_ack_ff !== 1'b1)
    begin
      check("cell_ack", cell_ack_ff, 1);
      summarize();
    end
    for (int n = 0; n < 400 && cell_q.size() < hl + pl; n++)
    begin
      tick();
      if (in_valid && rp)
        k++;
      if (op)
        cell_q.push_back(ob);
      in_valid = (k < pl);
      in_data = k[7:0];
      rp = in_ready_ff;
      op = out_valid_ff && out_ready;
      ob = out_byte_ff;
    end
    in_valid = 0;
    check("cell_len", cell_q.size(), hl + pl);
    if (cell_q.size() < hl + pl)
      summarize();
    for (int i = 0; i < 4; i++)
      check("header", cell_q[i].data, h[31-8*i -: 8]);
    if (!ts)
      check("hec", cell_q[4].data, hec(h));
    for (int i = hl; i < hl + pl; i++)
      check("payload", cell_q[i].data, i - hl);
    check("sof", cell_q[0].sof, 1);
    check("eof", cell_q[hl + pl - 1].eof, 1);
  endtask : t_cell

  // Control lost mid-cell aborts it, then no new cell is taken
  task automatic t_inhibit();
    cell_in = '{1'b0, 1'b0, 1'b0};
    cell_req = 1;
    for (int n = 0; n < 20 && cell_ack_ff !== 1'b1; n++)
      tick();
    check("cell_ack", cell_ack_ff, 1);
    cell_req = 0;
    ctrl_rx_ok = 0;
    tick();
    tick();
    check("cell_abort", cell_abort_ff, 1);
    check("out_valid", out_valid_ff, 0);
    check("tx_enable", tx_enable_ff, 0);
    cell_req = 1;
    repeat (4)
    begin
      tick();
      check("cell_ack", cell_ack_ff, 0);
    end
    cell_req = 0;
    ctrl_rx_ok = 1;
    tick();
    tick();
  endtask : t_inhibit

  // Check strobe stays high between probes; the caller lowers it
  task automatic probe(logic [47:0] m, logic [7:0] g, logic [15:0] e, logic xm, logic xl);
    fwd_mac = m;
    fwd_group = g;
    fwd_member = e;
    fwd_check = 1;
    tick();
    check("mac_hit", mac_hit_ff, xm);
    check("logical_hit", logical_hit_ff, xl);
  endtask : probe

  task automatic slot(logic [15:0] s, logic x);
    cur_slot = s;
    slot_tick = 1;
    tick();
    check("slot_grant", slot_grant_ff, x);
  endtask : slot

  initial
  begin
    {resetn, ctrl_rx_ok, mpeg_mode, security_on, security_gfc, assign_stb, logoff_stb} = '0;
    {cell_req, cell_in, in_valid, in_data, fwd_check, fwd_mac, fwd_group, fwd_member} = '0;
    {bp_load, bp_start, bp_reps, slot_tick, cur_slot, slow, assign_in} = '0;
    own_mac = 48'h0A0B_0C0D_0E0F;
    repeat (5) tick();
    resetn = 1;
    ctrl_rx_ok = 1;
    check("reset", {logged_on_ff, tx_enable_ff, out_valid_ff, cell_ack_ff}, 0);
    t_logon();
    slow = 1;
    t_cell(1'b1, 1'b1, 1'b0, 24'h120345);
    slow = 0;
    security_on = 1;
    security_gfc = 4'hA;
    t_cell(1'b0, 1'b0, 1'b0, 24'h120345);
    security_on = 0;
    logon(8'h3C, 16'h0101, 1'b0);
    assign_stb = 0;
    t_cell(1'b0, 1'b1, 1'b0, 24'h000005);
    mpeg_mode = 1;
    t_cell(1'b1, 1'b1, 1'b1, 24'h000000);
    mpeg_mode = 0;
    t_inhibit();
    probe(own_mac, 8'h3C, 16'h0101, 1, 1);
    probe(48'hFFFF_FFFF_FFFF, 8'h3D, 16'h0101, 1, 0);
    probe(48'h0A0B_0C0D_0E00, 8'h3C, 16'h0102, 0, 0);
    fwd_check = 0;
    bp_start = 16'h0010;
    bp_reps = 8'h03;
    bp_load = 1;
    tick();
    bp_load = 0;
    slot(16'h000F, 0);
    slot(16'h0010, 1);
    slot(16'h0012, 1);
    slot(16'h0013, 0);
    slot_tick = 0;
    logoff_stb = 1;
    tick();
    logoff_stb = 0;
    check("logged_on", logged_on_ff, 0);
    probe(own_mac, 8'h3C, 16'h0101, 1, 0);
    fwd_check = 0;
    slot(16'h0010, 0);
    slot_tick = 0;
    summarize();
  end
endmodule : rchf_framer_tb

// File: tb/rchf_sink.sv
// Far-side model taking the outgoing cell bytes.
// Assumes core_clk; when slow it accepts every other cycle.
`timescale 1ns/1ps
module rchf_sink (
  // Clock and mode
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic slow,
  // Stream handshake
  output      logic out_ready
);
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      out_ready <= 1'b0;
    else
      out_ready <= slow ? ~out_ready : 1'b1;
  end
endmodule : rchf_sink
